// ==== hw/poc_pin_ctrl.sv ====
// Power-off signal pin and single-wire pin drive control
`include "poc_regs.svh"
//
// Contract
// - Control status bit 15 reports power-off pin active; resets 0.
// - Control status bit 7 reports power-off enabled; resets 1.
// - Subcommand 0x0013 or config enable set turns power-off on.
// - Subcommand 0x0014 or config enable cleared turns power-off off.
// - Pack config bit 3 enables active pull-up drive of pin.
// - Pack config bit 2 selects pin polarity in power-off mode.
// - Power-off state needs feature enabled and pin select set.
// - Power-off state only in low-voltage hibernate; otherwise normal.
// - Pin high impedance after power-on reset regardless of polarity.
// - Pull-up is latched from the reset config value just after reset, so a written change never applies.
// - Pin select clear holds status bit 15 at 0; bit 7 does not depend on it.
// - Power-off mode pin drive follows pull-up and polarity table.
// - Priority: fuse-blow first, then interrupt mode, then power-off.
// - Fault interrupt needs its enable, except capacity threshold, battery high and low; pin select picks the pin.
// - Select 0: power-off pin carries interrupt per pull-up and irq polarity.
// - Select 1: single-wire pin carries interrupt per irq polarity.
// - Capacity threshold, battery high and low interrupt without an enable, unless trip point is enabled.
// - Overtemp charge/discharge interrupt if their time setting nonzero.
// - Internal short and tab disconnect interrupt only when enabled.
// - Trip raised at or below set level discharging, or at or above clear charging.
module poc_pin_ctrl #(
    parameter int CAP_W = 16
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ctrl_wr,
    input  wire logic [15:0]           ctrl_subcmd,
    input  wire logic                  pack_cfg_wr,
    input  wire logic [15:0]           pack_cfg_wdata,
    input  wire poc_pkg::poc_flags_s   flags,
    input  wire poc_pkg::poc_irq_cfg_s irq_cfg,
    input  wire poc_pkg::poc_pmode_e   power_mode,
    input  wire logic                  fuse_active,
    input  wire logic                  fuse_level,
    input  wire logic                  charging,
    input  wire logic                  discharging,
    input  wire logic [CAP_W-1:0]      remaining_charge,
    input  wire logic [CAP_W-1:0]      trip_set_level,
    input  wire logic [CAP_W-1:0]      trip_clear_level,
    input  wire logic                  trip_set_wr,
    input  wire logic                  trip_clear_wr,
    output logic [15:0]                control_status_word,
    output logic [15:0]                pack_config_word,
    output logic                       power_off_signal_pin_o,
    output logic                       power_off_signal_pin_oe,
    output logic                       single_wire_pin_o,
    output logic                       single_wire_pin_oe,
    output logic                       irq_active
);
    // Comparator width the logic can serve
    if (CAP_W < 1 || CAP_W > 32) begin : g_cap_w_check
        $error("CAP_W out of range");
    end

    poc_pkg::poc_state_s st;
    poc_pkg::poc_state_s next_st;

    // ==========================================================
    // Next state
    always_comb begin
        logic       pwr_en;
        logic       sel;
        logic       pol;
        logic       ipol;
        logic       pu;
        logic       pin_active;
        logic       irq;
        logic [6:0] rise;
        logic [6:0] en;
        logic       both_wr;
        poc_pkg::poc_pin_s ste_n;
        poc_pkg::poc_pin_s swi_n;
        pwr_en = 1'b0;
        sel = 1'b0;
        pol = 1'b0;
        ipol = 1'b0;
        pu = 1'b0;
        pin_active = 1'b0;
        irq = 1'b0;
        rise = '0;
        en = '0;
        both_wr = 1'b0;
        ste_n = '0;
        swi_n = '0;
        next_st = st;
        next_st.por_hold = 1'b0;
        if (pack_cfg_wr) begin
            next_st.pack_config_word = pack_cfg_wdata;
        end
        pwr_en = st.control_status_word[`POC_CS_PWR_OFF_EN_BIT];
        if ((ctrl_wr && ctrl_subcmd == `POC_SUB_SET_PWR_OFF) ||
            (pack_cfg_wr && pack_cfg_wdata[`POC_PC_PWR_OFF_EN_BIT] &&
             !st.pack_config_word[`POC_PC_PWR_OFF_EN_BIT])) begin
            pwr_en = 1'b1;
        end
        if ((ctrl_wr && ctrl_subcmd == `POC_SUB_CLR_PWR_OFF) ||
            (pack_cfg_wr && !pack_cfg_wdata[`POC_PC_PWR_OFF_EN_BIT] &&
             st.pack_config_word[`POC_PC_PWR_OFF_EN_BIT])) begin
            pwr_en = 1'b0;
        end
        sel = st.pack_config_word[`POC_PC_IRQ_SEL_BIT];
        pol = st.pack_config_word[`POC_PC_POLARITY_BIT];
        ipol = st.pack_config_word[`POC_PC_IRQ_POL_BIT];
        pu = st.pullup_live;
        if (st.por_hold) begin
            next_st.pullup_live = st.pack_config_word[`POC_PC_PULLUP_BIT];
        end
        en = {3'b111, irq_cfg.otc_time_nonzero, irq_cfg.otd_time_nonzero,
              irq_cfg.internal_short_enable, irq_cfg.tab_disconnect_enable};
        rise = flags & ~st.flags_q;
        next_st.flags_q = flags;
        next_st.irq_pend = st.irq_pend | (rise & en);
        if ((discharging && remaining_charge <= trip_set_level) ||
            (charging && remaining_charge >= trip_clear_level)) begin
            next_st.trip_irq = 1'b1;
        end
        next_st.trip_set_wr = st.trip_set_wr | trip_set_wr;
        next_st.trip_clr_wr = st.trip_clr_wr | trip_clear_wr;
        both_wr = next_st.trip_set_wr && next_st.trip_clr_wr;
        if (both_wr) begin
            next_st.trip_irq = 1'b0;
            next_st.trip_set_wr = 1'b0;
            next_st.trip_clr_wr = 1'b0;
            next_st.irq_pend = '0;
        end
        if (!irq_cfg.trip_point_enable) begin
            next_st.trip_irq = 1'b0;
        end
        irq = irq_cfg.trip_point_enable ? st.trip_irq : (|st.irq_pend);
        if (!sel) begin
            ste_n.oe = pu ? 1'b1 : (irq ^ ipol);
            ste_n.o = pu ? (irq ~^ ipol) : 1'b0;
        end else if (pwr_en) begin
            pin_active = (power_mode == poc_pkg::POC_PM_HIBERNATE_LOWV);
            ste_n.oe = pu ? 1'b1 : (pin_active ^ pol);
            ste_n.o = pu ? (pol ? pin_active : !pin_active) : 1'b0;
        end
        if (sel) begin
            swi_n.oe = irq ^ ipol;
            swi_n.o = 1'b0;
        end
        if (fuse_active) begin
            ste_n.oe = 1'b1;
            ste_n.o = fuse_level;
        end
        next_st.power_off_signal_pin = ste_n;
        next_st.single_wire_pin = swi_n;
        next_st.irq_active = irq;
        next_st.control_status_word[`POC_CS_PWR_OFF_EN_BIT] = pwr_en;
        next_st.control_status_word[`POC_CS_PIN_ACTIVE_BIT] = pin_active;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
            st.control_status_word <= `POC_CS_RESET;
            st.pack_config_word <= `POC_PC_RESET;
            st.por_hold <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign control_status_word = st.control_status_word;
    assign pack_config_word = st.pack_config_word;
    assign power_off_signal_pin_o = st.power_off_signal_pin.o;
    assign power_off_signal_pin_oe = st.power_off_signal_pin.oe;
    assign single_wire_pin_o = st.single_wire_pin.o;
    assign single_wire_pin_oe = st.single_wire_pin.oe;
    assign irq_active = st.irq_active;

    // ==========================================================
    // Checks
    // status after reset
    a_status_reset: assert property (@(posedge clk) $rose(rst_n) |->
        control_status_word == 16'h0080) else $error("status reset");
    a_pin_hiz_reset: assert property (@(posedge clk) !rst_n |=>
        !power_off_signal_pin_oe) else $error("pin not released");
    a_irq_reset: assert property (@(posedge clk) !rst_n |=>
        !irq_active && !single_wire_pin_oe) else $error("irq not quiet");
    a_status_spare: assert property (@(posedge clk) disable iff (!rst_n)
        control_status_word[14:8] == 7'h00 && control_status_word[6:0] == 7'h00)
        else $error("spare status bits");
    a_set_cmd_en: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_wr && ctrl_subcmd == 16'h0013 |=> control_status_word[7])
        else $error("set cmd");
    a_clr_cmd_dis: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_wr && ctrl_subcmd == 16'h0014 && !pack_cfg_wr |=> !control_status_word[7])
        else $error("clear cmd");

    // ==========================================================
    // Power-off pin checks
    // hibernate only
    a_active_hib: assert property (@(posedge clk) disable iff (!rst_n)
        control_status_word[15] |-> $past(power_mode) == poc_pkg::POC_PM_HIBERNATE_LOWV)
        else $error("active outside hibernate");
    a_active_gate: assert property (@(posedge clk) disable iff (!rst_n)
        control_status_word[15] |-> $past(pack_config_word[0]))
        else $error("active without select");
    a_active_en: assert property (@(posedge clk) disable iff (!rst_n)
        control_status_word[15] |-> control_status_word[7])
        else $error("active while disabled");
    a_pin_polarity_cfg_hiz: assert property (@(posedge clk) disable iff (!rst_n)
        control_status_word[15] && !$past(fuse_active) && !st.pullup_live |->
        power_off_signal_pin_oe == !$past(pack_config_word[2]))
        else $error("power-off drive table");
    a_pullup_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        !st.por_hold |=> $stable(st.pullup_live))
        else $error("pull-up changed while running");
    a_fuse_first: assert property (@(posedge clk) disable iff (!rst_n)
        fuse_active |=> power_off_signal_pin_oe && power_off_signal_pin_o == $past(fuse_level))
        else $error("fuse priority");

    // ==========================================================
    // Interrupt checks
    // irq mode drive table
    a_ste_irq_pol: assert property (@(posedge clk) disable iff (!rst_n)
        !fuse_active && !pack_config_word[0] && !st.pullup_live |=>
        power_off_signal_pin_oe == (irq_active ^ $past(pack_config_word[1]))
        && !power_off_signal_pin_o)
        else $error("irq drive table");
    a_swi_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !pack_config_word[0] |=> !single_wire_pin_oe)
        else $error("swi driven while unselected");
    a_swi_low_only: assert property (@(posedge clk) disable iff (!rst_n)
        single_wire_pin_oe |-> !single_wire_pin_o)
        else $error("swi driven high");
    a_always_src: assert property (@(posedge clk) disable iff (!rst_n)
        flags.battery_low_flag && !st.flags_q.battery_low_flag
        && !trip_set_wr && !trip_clear_wr |=> st.irq_pend[4])
        else $error("battery low not latched");
    a_otc_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !st.irq_pend[3] && !irq_cfg.otc_time_nonzero |=> !st.irq_pend[3])
        else $error("overtemp charge ungated");
    a_isd_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !st.irq_pend[1] && !irq_cfg.internal_short_enable |=> !st.irq_pend[1])
        else $error("internal short ungated");
    a_trip_only: assert property (@(posedge clk) disable iff (!rst_n)
        irq_cfg.trip_point_enable |=> irq_active == $past(st.trip_irq))
        else $error("other source while trip enabled");
    a_trip_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !irq_cfg.trip_point_enable |=> !st.trip_irq)
        else $error("trip while disabled");
    a_trip_hold: assert property (@(posedge clk) disable iff (!rst_n)
        st.trip_irq && irq_cfg.trip_point_enable && !trip_set_wr && !trip_clear_wr
        && !st.trip_set_wr && !st.trip_clr_wr |=> st.trip_irq)
        else $error("trip dropped");
    c_trip: cover property (@(posedge clk) disable iff (!rst_n) $rose(st.trip_irq));
    c_shutdown: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(control_status_word[15]));
    c_fault_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq_active));
    c_swi_irq: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(single_wire_pin_oe));
endmodule // poc_pin_ctrl

// ==== pkg/poc_regs.svh ====
// Field positions, reset values and subcommand codes of the power-off and irq pin block
`ifndef POC_REGS_SVH
`define POC_REGS_SVH
`define POC_CS_PIN_ACTIVE_BIT  15
`define POC_CS_PWR_OFF_EN_BIT  7
`define POC_CS_RESET           16'h0080
`define POC_PC_PULLUP_BIT      3
`define POC_PC_POLARITY_BIT    2
`define POC_PC_IRQ_POL_BIT     1
`define POC_PC_IRQ_SEL_BIT     0
`define POC_PC_PWR_OFF_EN_BIT  4
`define POC_PC_RESET           16'h0000
`define POC_SUB_SET_PWR_OFF    16'h0013
`define POC_SUB_CLR_PWR_OFF    16'h0014
`endif

// ==== pkg/poc_pkg.sv ====
// Types of the power-off and irq pin block
package poc_pkg;
    typedef enum logic [1:0] {
        POC_PM_NORMAL,
        POC_PM_SLEEP,
        POC_PM_HIBERNATE_LOWV,
        POC_PM_HIBERNATE_OTHER
    } poc_pmode_e;

    typedef struct packed {
        logic capacity_threshold_flag;
        logic battery_high_flag;
        logic battery_low_flag;
        logic overtemp_charge_flag;
        logic overtemp_discharge_flag;
        logic internal_short_flag;
        logic tab_disconnect_flag;
    } poc_flags_s;

    typedef struct packed {
        logic internal_short_enable;
        logic tab_disconnect_enable;
        logic trip_point_enable;
        logic otc_time_nonzero;
        logic otd_time_nonzero;
    } poc_irq_cfg_s;

    typedef struct packed {
        logic o;
        logic oe;
    } poc_pin_s;

    typedef struct packed {
        logic [15:0] control_status_word;
        logic [15:0] pack_config_word;
        logic        pullup_live;
        logic        por_hold;
        poc_flags_s  flags_q;
        logic [6:0]  irq_pend;
        logic        trip_irq;
        logic        trip_set_wr;
        logic        trip_clr_wr;
        poc_pin_s    power_off_signal_pin;
        poc_pin_s    single_wire_pin;
        logic        irq_active;
    } poc_state_s;
endpackage

// ==== tb/poc_host_model.sv ====
// Host and power-off circuit model facing the pins
module poc_host_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic release_req,
    input  wire logic po_o,
    input  wire logic po_oe,
    input  wire logic sw_o,
    input  wire logic sw_oe,
    output logic      trip_set_wr,
    output logic      trip_clear_wr,
    output logic      po_level,
    output logic      sw_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] seq;
    assign trip_set_wr   = seq[0];
    assign trip_clear_wr = seq[1];
    always_ff @(posedge clk) begin
        seq <= rst_n ? {seq[0], release_req} : 2'h0;
    end
    // Released wire shows a changing level
    always_ff @(posedge clk) begin
        po_level <= !rst_n ? 1'b0 : (po_oe ? po_o : ~po_level);
        sw_level <= !rst_n ? 1'b0 : (sw_oe ? sw_o : ~sw_level);
    end
endmodule // poc_host_model

// ==== tb/power_off_and_irq_pin_control_tb_top.sv ====
// Self-checking bench of the power-off and irq pin block
module power_off_and_irq_pin_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, ctrl_wr = 0, pack_cfg_wr = 0, rel = 0;
    logic fa = 0, fl_lv = 0, chg = 0, dsg = 0, ts_wr, tc_wr, po_o, po_oe, sw_o, sw_oe, irq;
    logic [15:0] sub = 16'h0, pdat = 16'h0, rc = 16'h0064, tset = 16'h0014, tclr = 16'h0050;
    logic [15:0] cs, pw;
    poc_pkg::poc_flags_s   fl = '0;
    poc_pkg::poc_irq_cfg_s ic = '0;
    poc_pkg::poc_pmode_e   pm = poc_pkg::POC_PM_NORMAL;
    int n_mismatch = 0, total_checks = 0;
    int fb[4] = '{1, 0, 3, 2};
    int eb[4] = '{4, 3, 1, 0};
    wire [1:0] po = {po_o & po_oe, po_oe};
    wire [1:0] sw = {sw_o & sw_oe, sw_oe};
    always #10 clk = ~clk;
    poc_pin_ctrl poc_pin_ctrl_i (.clk(clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr),
        .ctrl_subcmd(sub), .pack_cfg_wr(pack_cfg_wr), .pack_cfg_wdata(pdat), .flags(fl),
        .irq_cfg(ic), .power_mode(pm), .fuse_active(fa), .fuse_level(fl_lv),
        .charging(chg), .discharging(dsg), .remaining_charge(rc), .trip_set_level(tset),
        .trip_clear_level(tclr), .trip_set_wr(ts_wr), .trip_clear_wr(tc_wr),
        .control_status_word(cs), .pack_config_word(pw), .power_off_signal_pin_o(po_o),
        .power_off_signal_pin_oe(po_oe), .single_wire_pin_o(sw_o),
        .single_wire_pin_oe(sw_oe), .irq_active(irq));
    poc_host_model poc_host_model_i (.clk(clk), .rst_n(rst_n), .release_req(rel),
        .po_o(po_o), .po_oe(po_oe), .sw_o(sw_o), .sw_oe(sw_oe), .trip_set_wr(ts_wr),
        .trip_clear_wr(tc_wr), .po_level(), .sw_level());
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle();
        repeat (4) @(negedge clk);
    endtask
    task automatic cmd(input logic [15:0] c);
        sub = c;
        ctrl_wr = 1;
        @(negedge clk);
        ctrl_wr = 0;
        settle();
    endtask
    task automatic cfg(input logic [15:0] d);
        pdat = d;
        pack_cfg_wr = 1;
        @(negedge clk);
        pack_cfg_wr = 0;
        settle();
    endtask
    task automatic release_irq();
        fl = '0;
        rel = 1;
        @(negedge clk);
        rel = 0;
        settle();
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        settle();
        chk(cs, 16'h0080);
        chk({po_oe, sw_oe, pw}, 16'h0000);
        cmd(16'h0014);
        chk(cs[7], 1'h0);
        cmd(16'h0055);
        chk(cs[7], 1'h0);
        cmd(16'h0013);
        chk(cs[7], 1'h1);
        chk(po, 2'h0);
        fl.capacity_threshold_flag = 1;
        settle();
        chk({irq, po}, 3'h5);
        release_irq();
        chk(po, 2'h0);
        cfg(16'h0002);
        chk(po, 2'h1);
        fl.battery_low_flag = 1;
        settle();
        chk(po, 2'h0);
        release_irq();
        cfg(16'h0001);
        for (int i = 0; i < 8; i++) begin
            ic[eb[i/2]] = i[0];
            fl[fb[i/2]] = 1;
            settle();
            chk(sw, {1'h0, i[0]});
            release_irq();
            ic = '0;
        end
        ic.trip_point_enable = 1;
        fl.battery_high_flag = 1;
        settle();
        chk(sw, 2'h0);
        rc = 16'h0014;
        dsg = 1;
        settle();
        chk(sw, 2'h1);
        dsg = 0;
        release_irq();
        chk(sw, 2'h0);
        ic = '0;
        cfg(16'h0011);
        pm = poc_pkg::POC_PM_HIBERNATE_LOWV;
        settle();
        chk({cs[15], po}, 3'h5);
        pm = poc_pkg::POC_PM_SLEEP;
        settle();
        chk({cs[15], po}, 3'h0);
        cfg(16'h0015);
        chk(po, 2'h1);
        pm = poc_pkg::POC_PM_HIBERNATE_LOWV;
        settle();
        chk(po, 2'h0);
        cfg(16'h0010);
        chk({cs[7], po}, 3'h4);
        pm = poc_pkg::POC_PM_NORMAL;
        cfg(16'h0019);
        chk(po, 2'h0);
        conclude();
    end
endmodule // power_off_and_irq_pin_control_tb_top
